// *** dv/data_window_shift_tb.sv ***
`timescale 1ns/1ps
module data_window_shift_tb;
   logic        core_clk, reset_n, reg_we, reg_re, irq;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, r;
   logic        open_req, open_extended, call_req, return_req, shift_req, acc_req;
   logic [19:0] open_start, acc_addr, block_base_register, eb;
   logic [15:0] open_len, shift_accu, acc_index, accumulator_low_word, block_length_register, el;
   logic [3:0]  cond_codes;
   logic        shift_done, logic_result_bit, acc_valid, acc_error, eo;
   logic        block_is_open, block_is_extended, block_is_long;
   logic [31:0] seed = 32'h0000_6179;
   logic [35:0] stk[$];
   int          fails = 0;
   int          checks = 0;

   data_window_shift u_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
      .reg_rdata, .open_req, .open_extended, .open_start, .open_len, .call_req, .return_req,
      .shift_req, .shift_accu, .shift_done, .logic_result_bit, .accumulator_low_word,
      .cond_codes, .acc_req, .acc_index, .acc_valid, .acc_error, .acc_addr,
      .block_base_register, .block_length_register, .block_is_open, .block_is_extended,
      .block_is_long, .irq);
   user_program_model u_prog (.core_clk, .open_req, .call_req, .return_req, .shift_req,
      .acc_req, .open_extended, .open_start, .open_len, .shift_accu, .acc_index);

   // ==========================================
   // Helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] exp_code(input logic o, input logic [15:0] l, s);
      if (!o) return 16'hb401;
      if (s[3:0] != 4'h0) return 16'hb410;
      if (s[15] || s >= l) return 16'hb411;
      return 16'h0000;
   endfunction
   task automatic check(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_we <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_re <= 1'b0;
      #1;
      check(reg_rdata, e);
   endtask
   task automatic win_chk();
      check(block_base_register, eb);
      check(block_length_register, el);
      check(block_is_open, eo);
   endtask
   task automatic sh(input logic [15:0] s);
      logic [15:0] code;
      code = exp_code(eo, el, s);
      u_prog.op(5'h02, 20'h0, s, 1'b0);
      check(shift_done, 1'h1);
      check(logic_result_bit, code != 16'h0);
      check(accumulator_low_word, code);
      check(cond_codes, 4'h0);
      if (code == 16'h0) begin
         eb = eb + s;
         el = el - s;
      end
      win_chk();
   endtask
   task automatic opn(input logic [19:0] a, input logic [15:0] l, input logic x);
      u_prog.op(5'h10, a, l, x);
      eb = a + 20'h00005;
      el = l;
      eo = 1'b1;
      win_chk();
      check(block_is_long, l > 16'h0100);
      check(block_is_extended, x);
   endtask
   task automatic ac(input logic [15:0] i);
      u_prog.op(5'h01, 20'h0, i, 1'b0);
      check(acc_valid, 1'h1);
      check(acc_error, !eo || i >= el);
      check(acc_addr, 20'(eb + i));
   endtask
   task automatic cl();
      u_prog.op(5'h08, 20'h0, 16'h0, 1'b0);
      stk.push_back({eb, el});
      win_chk();
   endtask
   task automatic rt();
      u_prog.op(5'h04, 20'h0, 16'h0, 1'b0);
      if (stk.size() > 0) {eb, el} = stk.pop_back();
      win_chk();
   endtask

   // ==========================================
   // Clock, watchdog, sequence
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      tally_and_finish();
   end
   initial begin
      {reset_n, reg_we, reg_re, eo} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      eb = 20'h0;
      el = 16'h0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(window_pkg::REG_CTRL, 32'h1);
      rd(window_pkg::REG_MASK, 32'h0);
      rd(8'h40, 32'h0);
      sh(16'h0010);
      opn(20'h04000, 16'h0100, 1'b0);
      sh(16'h0020);
      ac(16'h0003);
      ac(16'h00df);
      ac(16'h00e0);
      // Status now holds shift ok, shift error and access error
      wr(window_pkg::REG_MASK, 32'h1);
      @(posedge core_clk);
      #1;
      check(irq, 1);
      wr(window_pkg::REG_STATUS, 32'hf);
      @(posedge core_clk);
      #1;
      check(irq, 0);
      sh(16'h0003);
      rd(window_pkg::REG_STATUS, 32'h2);
      check(irq, 0);
      wr(window_pkg::REG_MASK, 32'h0);
      wr(window_pkg::REG_CTRL, 32'h0);
      u_prog.op(5'h02, 20'h0, 16'h0010, 1'b0);
      check(shift_done, 0);
      wr(window_pkg::REG_CTRL, 32'h1);
      opn(20'h04000, 16'h0100, 1'b1);
      sh(16'h0010);
      cl();
      sh(16'h0020);
      rt();
      rd(window_pkg::REG_BASE, {12'h0, eb});
      rd(window_pkg::REG_LENGTH, {16'h0, el});
      rd(window_pkg::REG_RESULT, 32'h0006_0000);
      rt();
      rd(window_pkg::REG_STATUS, 32'hb);
      opn(20'h08000, 16'h0200, 1'b1);
      for (int n = 0; n < 80; n++) begin
         r = xs();
         case (r[2:0])
            3'h0, 3'h1: sh({8'h00, r[15:12], 4'h0});
            3'h2: sh(r[31:16]);
            3'h3: sh(el);
            3'h4: sh(16'hfff0);
            3'h5: ac(r[31:16] & 16'h01ff);
            3'h6: begin
               if (stk.size() < 8 && r[8]) cl();
               else rt();
            end
            default: opn({r[31:16], 4'h0}, r[15:0], r[9]);
         endcase
      end
      tally_and_finish();
   end
endmodule

// *** dv/user_program_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Calling program: one request per call
module user_program_model (
   // Clock
   input  wire logic        core_clk,
   // Requests
   output logic             open_req,
   output logic             call_req,
   output logic             return_req,
   output logic             shift_req,
   output logic             acc_req,
   output logic             open_extended,
   output logic [19:0]      open_start,
   output logic [15:0]      open_len,
   output logic [15:0]      shift_accu,
   output logic [15:0]      acc_index
);
   initial begin
      {open_req, call_req, return_req, shift_req, acc_req} = 5'h00;
      {open_extended, open_start, open_len, shift_accu, acc_index} = '0;
   end

   // Kind is {open, call, return, shift, access}; ordinary shifts follow an open
   task automatic op(input logic [4:0] k, input logic [19:0] a, input logic [15:0] v,
                     input logic x);
      @(posedge core_clk);
      {open_req, call_req, return_req, shift_req, acc_req} <= k;
      open_extended <= x;
      open_start    <= a;
      open_len      <= v;
      shift_accu    <= v;
      acc_index     <= v;
      @(posedge core_clk);
      {open_req, call_req, return_req, shift_req, acc_req} <= 5'h00;
      // Stale qualifiers inverted so a late sample cannot look right
      open_start    <= ~a;
      open_len      <= ~v;
      shift_accu    <= ~v;
      acc_index     <= ~v;
      #1;
   endtask
endmodule

// *** dv/window_checker.sv ***
`timescale 1ns/1ps
// ==========================================
// Port-level checks of shift, open and access
module window_checker (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset_n,
   // Requests
   input wire logic        open_req,
   input wire logic [19:0] open_start,
   input wire logic [15:0] open_len,
   input wire logic        shift_req,
   input wire logic [15:0] shift_accu,
   input wire logic        acc_req,
   input wire logic [15:0] acc_index,
   // Answers
   input wire logic        shift_done,
   input wire logic        logic_result_bit,
   input wire logic [15:0] accumulator_low_word,
   input wire logic [3:0]  cond_codes,
   input wire logic        acc_valid,
   input wire logic        acc_error,
   input wire logic [19:0] acc_addr,
   input wire logic [19:0] block_base_register,
   input wire logic [15:0] block_length_register,
   input wire logic        block_is_open,
   input wire logic        block_is_long
);
   wire [19:0] base      = block_base_register;
   wire [15:0] len       = block_length_register;
   wire [15:0] low_word  = accumulator_low_word;
   wire        res_bit   = logic_result_bit;
   wire        step_bad  = shift_accu[3:0] != 4'h0;
   wire        range_bad = shift_accu[15] || (shift_accu >= len);
   wire        idx_bad   = (acc_index >= len) || !block_is_open;
   wire        long_len  = open_len > 16'h0100;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_ok_move;
      shift_done && !res_bit |-> base == $past(base) + $past(shift_accu) &&
         len == $past(len) - $past(shift_accu);
   endproperty
   a_ok_move: assert property (p_ok_move) else $error("window move wrong");
   property p_ok_clear;
      shift_done && !res_bit |-> low_word == 16'h0 && cond_codes == 4'h0;
   endproperty
   a_ok_clear: assert property (p_ok_clear) else $error("success not cleared");
   property p_fail_keep;
      shift_done && res_bit |-> $stable(base) && $stable(len) && cond_codes == 4'h0;
   endproperty
   a_fail_keep: assert property (p_fail_keep) else $error("failed shift moved");
   property p_no_block;
      shift_done && !$past(block_is_open) |-> res_bit && low_word == 16'hb401;
   endproperty
   a_no_block: assert property (p_no_block) else $error("missing b401");
   property p_step;
      shift_done && $past(block_is_open) && $past(step_bad) |-> res_bit && low_word == 16'hb410;
   endproperty
   a_step: assert property (p_step) else $error("missing b410");
   property p_range;
      shift_done && $past(block_is_open) && !$past(step_bad) && $past(range_bad)
         |-> res_bit && low_word == 16'hb411;
   endproperty
   a_range: assert property (p_range) else $error("missing b411");
   property p_open;
      open_req |=> block_is_open && base == $past(open_start) + 20'h00005 &&
         len == $past(open_len) && block_is_long == $past(long_len);
   endproperty
   a_open: assert property (p_open) else $error("open values wrong");
   property p_access;
      acc_req |=> acc_valid && acc_error == $past(idx_bad) &&
         acc_addr == $past(base) + $past(acc_index);
   endproperty
   a_access: assert property (p_access) else $error("access answer wrong");

   c_ok: cover property (shift_done && !res_bit);
   c_err: cover property (shift_done && res_bit);
   c_acc_err: cover property (acc_valid && acc_error);
endmodule

bind data_window_shift window_checker u_chk (
   .core_clk, .reset_n, .open_req, .open_start, .open_len, .shift_req, .shift_accu,
   .acc_req, .acc_index, .shift_done, .logic_result_bit, .accumulator_low_word,
   .cond_codes, .acc_valid, .acc_error, .acc_addr, .block_base_register,
   .block_length_register, .block_is_open, .block_is_long
);

// *** rtl/data_window_shift.sv ***
`timescale 1ns/1ps
module data_window_shift (
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          reset_n,
   // Register port
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_we,
   input  wire logic                          reg_re,
   output logic [31:0]                        reg_rdata,
   // Block open
   input  wire logic                          open_req,
   input  wire logic                          open_extended,
   input  wire logic [window_pkg::ADDR_W-1:0] open_start,
   input  wire logic [window_pkg::WORD_W-1:0] open_len,
   // Logic block nesting
   input  wire logic                          call_req,
   input  wire logic                          return_req,
   // Window shift service
   input  wire logic                          shift_req,
   input  wire logic [window_pkg::WORD_W-1:0] shift_accu,
   output logic                               shift_done,
   output logic                               logic_result_bit,
   output logic [window_pkg::WORD_W-1:0]      accumulator_low_word,
   output logic [window_pkg::CC_W-1:0]        cond_codes,
   // Data word access
   input  wire logic                          acc_req,
   input  wire logic [window_pkg::WORD_W-1:0] acc_index,
   output logic                               acc_valid,
   output logic                               acc_error,
   output logic [window_pkg::ADDR_W-1:0]      acc_addr,
   // Window state
   output logic [window_pkg::ADDR_W-1:0]      block_base_register,
   output logic [window_pkg::WORD_W-1:0]      block_length_register,
   output logic                               block_is_open,
   output logic                               block_is_extended,
   output logic                               block_is_long,
   // Interrupt
   output logic                               irq
);
   // ==========================================================
   // Reset release
   // Asserts at once, leaves only on a clock edge
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ==========================================================
   // Window state
   logic [window_pkg::ADDR_W-1:0] base_q;
   logic [window_pkg::ADDR_W-1:0] base_d;
   logic [window_pkg::WORD_W-1:0] len_q;
   logic [window_pkg::WORD_W-1:0] len_d;
   logic                          open_q;
   logic                          open_d;
   logic                          ext_q;
   logic                          long_q;

   // Eight levels; deeper nesting is refused and flagged
   window_stack_if stk ();

   window_stack u_stack (
      .clk   (core_clk),
      .rst_n (rst_n),
      .stk   (stk)
   );

   logic                          chk_ok;
   logic [window_pkg::WORD_W-1:0] chk_code;

   shift_check u_check (
      .block_open (open_q),
      .length     (len_q),
      .shift_num  (shift_accu),
      .ok         (chk_ok),
      .err_code   (chk_code)
   );

   // Service enable from control register
   logic ctrl_q;

   // One operation per cycle: open, return, call, shift
   logic do_open;
   logic do_return;
   logic do_call;
   logic do_shift;
   logic shift_good;
   logic ret_empty;
   logic restore;

   // Fixed priority keeps one window update per edge
   assign do_open    = open_req;
   assign do_return  = return_req && !do_open;
   assign do_call    = call_req && !do_open && !do_return;
   assign do_shift   = shift_req && ctrl_q && !do_open && !do_return && !do_call;
   assign shift_good = do_shift && chk_ok;
   assign ret_empty  = do_return && stk.empty;
   assign restore    = do_return && !stk.empty;

   // Calls save the window but leave it in place; a full stack saves nothing
   assign stk.push      = do_call;
   assign stk.pop       = do_return;
   assign stk.push_base = base_q;
   assign stk.push_len  = len_q;
   assign stk.push_open = open_q;

   // Base skips the block header; a return reloads the window saved by the last call
   // No carry check: the base wraps past the top of the address range
   assign base_d = do_open    ? open_start + window_pkg::HEADER_WORDS :
                   restore    ? stk.pop_base :
                   shift_good ? base_q + {4'h0, shift_accu} :
                   base_q;
   assign len_d  = do_open    ? open_len :
                   restore    ? stk.pop_len :
                   shift_good ? len_q - shift_accu :
                   len_q;
   assign open_d = do_open ? 1'b1 :
                   restore    ? stk.pop_open :
                   open_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_q <= '0;
         len_q  <= '0;
         open_q <= 1'b0;
      end else begin
         base_q <= base_d;
         len_q  <= len_d;
         open_q <= open_d;
      end
   end

   // Block type and size flag follow the latest open
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_q  <= 1'b0;
         long_q <= 1'b0;
      end else if (do_open) begin
         ext_q  <= open_extended;
         long_q <= open_len > (window_pkg::LONG_BLOCK_WORDS - 16'(window_pkg::HEADER_WORDS));
      end
   end

   // ==========================================================
   // Shift result
   logic                          done_q;
   logic                          rlo_q;
   logic [window_pkg::WORD_W-1:0] accu_q;
   logic [window_pkg::CC_W-1:0]   cc_q;
   logic                          rlo_d;
   logic [window_pkg::WORD_W-1:0] accu_d;

   // A good shift leaves zero behind, a failure its code
   assign rlo_d  = !chk_ok;
   assign accu_d = chk_ok ? 16'h0000 : chk_code;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         rlo_q  <= 1'b0;
         accu_q <= '0;
         cc_q   <= '0;
      end else begin
         done_q <= do_shift;
         if (do_shift) begin
            rlo_q  <= rlo_d;
            accu_q <= accu_d;
            cc_q   <= '0;
         end
      end
   end

   // ==========================================================
   // Data word access
   logic                          acc_valid_q;
   logic                          acc_err_q;
   logic [window_pkg::ADDR_W-1:0] acc_addr_q;
   logic                          acc_bad;
   logic                          acc_err_d;
   logic [window_pkg::ADDR_W-1:0] acc_addr_d;

   // Checked against the current, possibly reduced, length
   assign acc_bad    = !open_q || (acc_index >= len_q);
   assign acc_err_d  = acc_req && acc_bad;
   // Same word moves to a lower index after a shift
   assign acc_addr_d = base_q + {4'h0, acc_index};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_valid_q <= 1'b0;
         acc_err_q   <= 1'b0;
         acc_addr_q  <= '0;
      end else begin
         acc_valid_q <= acc_req;
         acc_err_q   <= acc_err_d;
         if (acc_req) begin
            acc_addr_q <= acc_addr_d;
         end
      end
   end

   // ==========================================================
   // Registers and interrupt
   logic [window_pkg::STATUS_W-1:0] status_q;
   logic [window_pkg::STATUS_W-1:0] mask_q;
   logic [window_pkg::STATUS_W-1:0] events;
   logic [window_pkg::STATUS_W-1:0] w1c;
   logic [31:0]                     rdata_q;
   logic [31:0]                     rd_mux;
   logic                            irq_q;
   logic                            wr_ctrl;
   logic                            wr_status;
   logic                            wr_mask;
   logic                            sel_ctrl;
   logic                            sel_status;
   logic                            sel_mask;
   logic                            sel_base;
   logic                            sel_length;
   logic                            sel_result;
   logic [31:0]                     result_word;
   logic [window_pkg::STATUS_W-1:0] status_d;
   logic                            irq_d;

   assign events[window_pkg::ST_SHIFT_OK]  = shift_good;
   assign events[window_pkg::ST_SHIFT_ERR] = do_shift && !chk_ok;
   assign events[window_pkg::ST_ACC_ERR]   = acc_err_d;
   assign events[window_pkg::ST_STACK_ERR] = (do_call && stk.full) || ret_empty;

   // Address decode
   assign sel_ctrl   = (reg_addr == window_pkg::REG_CTRL);
   assign sel_status = (reg_addr == window_pkg::REG_STATUS);
   assign sel_mask   = (reg_addr == window_pkg::REG_MASK);
   assign sel_base   = (reg_addr == window_pkg::REG_BASE);
   assign sel_length = (reg_addr == window_pkg::REG_LENGTH);
   assign sel_result = (reg_addr == window_pkg::REG_RESULT);

   assign wr_ctrl   = reg_we && sel_ctrl;
   assign wr_status = reg_we && sel_status;
   assign wr_mask   = reg_we && sel_mask;
   assign w1c       = wr_status ? reg_wdata[window_pkg::STATUS_W-1:0] : '0;

   // Sticky bits; a new event wins over a same-cycle clear
   for (genvar b = 0; b < window_pkg::STATUS_W; b++) begin : g_status
      assign status_d[b] = events[b] || (status_q[b] && !w1c[b]);
   end
   assign irq_d = |(status_d & mask_q);

   // Unmapped addresses and unused bits read as zero
   assign result_word = {9'h0, stk.depth, ext_q, open_q, rlo_q, accu_q};
   assign rd_mux =
      sel_ctrl   ? {31'h0, ctrl_q} :
      sel_status ? {28'h0, status_q} :
      sel_mask   ? {28'h0, mask_q} :
      sel_base   ? {12'h0, base_q} :
      sel_length ? {16'h0, len_q} :
      sel_result ? result_word :
      32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q   <= window_pkg::CTRL_RESET;
         mask_q   <= window_pkg::MASK_RESET;
         status_q <= window_pkg::STATUS_RESET;
         rdata_q  <= '0;
         irq_q    <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata[0];
         end
         if (wr_mask) begin
            mask_q <= reg_wdata[window_pkg::STATUS_W-1:0];
         end
         status_q <= status_d;
         rdata_q  <= reg_re ? rd_mux : 32'h0000_0000;
         irq_q    <= irq_d;
      end
   end

   // ==========================================================
   // Outputs
   // Each one a flop, no logic behind the registers
   assign reg_rdata             = rdata_q;
   assign shift_done            = done_q;
   assign logic_result_bit      = rlo_q;
   assign accumulator_low_word  = accu_q;
   assign cond_codes            = cc_q;
   assign acc_valid             = acc_valid_q;
   assign acc_error             = acc_err_q;
   assign acc_addr              = acc_addr_q;
   assign block_base_register   = base_q;
   assign block_length_register = len_q;
   assign block_is_open         = open_q;
   assign block_is_extended     = ext_q;
   assign block_is_long         = long_q;
   assign irq                   = irq_q;
endmodule

// *** rtl/shift_check.sv ***
`timescale 1ns/1ps
module shift_check (
   // Current window
   input  wire logic                            block_open,
   input  wire logic [window_pkg::WORD_W-1:0]   length,
   // Request
   input  wire logic [window_pkg::WORD_W-1:0]   shift_num,
   // Verdict
   output logic                                 ok,
   output logic [window_pkg::WORD_W-1:0]        err_code
);
   logic not_step;
   logic out_range;

   assign not_step  = (shift_num & (window_pkg::STEP_WORDS - 16'h1)) != 16'h0;
   assign out_range = shift_num[window_pkg::WORD_W-1] || (shift_num >= length);

   // Priority: no block, then step, then range
   assign ok       = block_open && !not_step && !out_range;
   assign err_code = !block_open ? window_pkg::ERR_NOT_OPEN :
                     not_step    ? window_pkg::ERR_NOT_STEP :
                     out_range   ? window_pkg::ERR_RANGE    :
                     16'h0000;
endmodule

// *** rtl/window_stack.sv ***
`timescale 1ns/1ps
module window_stack (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Owner side
   window_stack_if.store    stk
);
   logic [window_pkg::ADDR_W-1:0]      base_mem [window_pkg::STACK_DEPTH];
   logic [window_pkg::WORD_W-1:0]      len_mem  [window_pkg::STACK_DEPTH];
   logic [window_pkg::STACK_DEPTH-1:0] open_mem;
   logic [window_pkg::STACK_PTR_W-1:0] ptr_q;
   logic [window_pkg::STACK_PTR_W-1:0] top_idx;
   logic                               do_push;
   logic                               do_pop;

   assign stk.empty = (ptr_q == '0);
   assign stk.full  = (ptr_q == window_pkg::STACK_PTR_W'(window_pkg::STACK_DEPTH));
   assign stk.depth = ptr_q;
   assign do_push   = stk.push && !stk.full;
   assign do_pop    = stk.pop && !stk.empty;
   assign top_idx   = ptr_q - 4'h1;
   assign stk.pop_base = base_mem[top_idx[2:0]];
   assign stk.pop_len  = len_mem[top_idx[2:0]];
   assign stk.pop_open = open_mem[top_idx[2:0]];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= '0;
      end else if (do_push) begin
         ptr_q <= ptr_q + 4'h1;
      end else if (do_pop) begin
         ptr_q <= top_idx;
      end
   end

   // Storage needs no reset; entries are only read below the pointer
   always_ff @(posedge clk) begin
      if (do_push) begin
         base_mem[ptr_q[2:0]] <= stk.push_base;
         len_mem[ptr_q[2:0]]  <= stk.push_len;
         open_mem[ptr_q[2:0]] <= stk.push_open;
      end
   end
endmodule

// *** shared/window_pkg.sv ***
package window_pkg;
   // ==========================================================
   // Widths and sizes
   localparam int ADDR_W      = 20;
   localparam int WORD_W      = 16;
   localparam int STACK_DEPTH = 8;
   localparam int STACK_PTR_W = 4;
   localparam int STATUS_W    = 4;
   localparam int CC_W        = 4;

   localparam logic [WORD_W-1:0] STEP_WORDS       = 16'h0010;
   localparam logic [WORD_W-1:0] WINDOW_WORDS     = 16'h0100;
   localparam logic [ADDR_W-1:0] HEADER_WORDS     = 20'h00005;
   localparam logic [WORD_W-1:0] LONG_BLOCK_WORDS = 16'h0105;

   // ==========================================================
   // Error identifiers
   localparam logic [WORD_W-1:0] ERR_NOT_OPEN = 16'hb401;
   localparam logic [WORD_W-1:0] ERR_NOT_STEP = 16'hb410;
   localparam logic [WORD_W-1:0] ERR_RANGE    = 16'hb411;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK   = 8'h08;
   localparam logic [7:0] REG_BASE   = 8'h0c;
   localparam logic [7:0] REG_LENGTH = 8'h10;
   localparam logic [7:0] REG_RESULT = 8'h14;

   // Status bit positions
   localparam int ST_SHIFT_OK  = 0;
   localparam int ST_SHIFT_ERR = 1;
   localparam int ST_ACC_ERR   = 2;
   localparam int ST_STACK_ERR = 3;

   // Reset values
   localparam logic       CTRL_RESET   = 1'b1;
   localparam logic [3:0] MASK_RESET   = 4'h0;
   localparam logic [3:0] STATUS_RESET = 4'h0;
endpackage

// *** shared/window_stack_if.sv ***
`timescale 1ns/1ps
interface window_stack_if;
   logic                              push;
   logic                              pop;
   logic [window_pkg::ADDR_W-1:0]     push_base;
   logic [window_pkg::WORD_W-1:0]     push_len;
   logic                              push_open;
   logic [window_pkg::ADDR_W-1:0]     pop_base;
   logic [window_pkg::WORD_W-1:0]     pop_len;
   logic                              pop_open;
   logic                              empty;
   logic                              full;
   logic [window_pkg::STACK_PTR_W-1:0] depth;

   modport owner (output push, pop, push_base, push_len, push_open,
                  input pop_base, pop_len, pop_open, empty, full, depth);
   modport store (input push, pop, push_base, push_len, push_open,
                  output pop_base, pop_len, pop_open, empty, full, depth);
endinterface
